// [include/spi_port_defs.svh]
/*
  Register indices, field positions, reset values and codes of the SPI port.
  Assumes inclusion by bare name from the package and the design files.
*/
`ifndef SPI_PORT_DEFS_SVH
`define SPI_PORT_DEFS_SVH

`define SPI_ADDR_W 12
`define SPI_DATA_W 32
// register indices; byte address is four times the index
`define SPI_IDX_CTRL 10'h09A
`define SPI_IDX_DATA 10'h09B
`define SPI_IDX_DRV 10'h09D
`define SPI_IDX_PAI 10'h0A5
`define SPI_IDX_AIE 10'h0A6
`define SPI_IDX_STAT 10'h0C0
`define SPI_IDX_EXT 10'h0D8
`define SPI_RST_BYTE 8'h00
// serial_port_control fields
`define SPI_CPOL_BIT 0
`define SPI_CPHA_BIT 1
`define SPI_MASTER_SELECT_BIT 2
`define SPI_ORDER_BIT 3
`define SPI_RSVD_MASK 8'hEF
`define SPI_DIV_HI 7
`define SPI_DIV_LO 5
// serial_output_drive_control fields
`define SPI_OUTPUT_DRIVE_ENABLE_BIT 3
`define SPI_DRIVE_CHANGE_DEFERRED_BIT 4
`define SPI_CLK_EN_BIT 5
// irq bits, shared by status, mask and enable readback
`define SPI_IRQ_TX_BIT 3
`define SPI_IRQ_RX_BIT 2
`define SPI_EXT_AUX_BIT 4
`define SPI_PAI_NONE 4'h0
`define SPI_PAI_RX 4'h3
`define SPI_PAI_TX 4'h4
`define SPI_AUX_VECTOR 16'h0033
`define SPI_LAST_EDGE 4'hF

`endif

// [include/spi_port_pkg.sv]
/*
  Types of the SPI port: transfer states, pin bundle and core state.
  Assumes spi_port_defs.svh on the include path.
*/
`include "spi_port_defs.svh"

package spi_port_pkg;
  typedef enum logic {XF_IDLE, XF_RUN} xfer_e;

  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso;
  } spi_pin_s;

  typedef struct packed {
    logic [7:0] ctrl;
    logic clk_en;
    logic drv;
    logic drv_pend;
    logic drv_new;
    logic [7:0] txb;
    logic tx_full;
    logic [7:0] rxb;
    logic rx_st;
    logic tx_st;
    logic rx_msk;
    logic tx_msk;
    logic ext_en;
    xfer_e fsm;
    logic [3:0] cnt;
    logic sck;
    logic sck_prev;
    logic ack;
    logic [`SPI_DATA_W-1:0] rdata;
  } core_state_s;
endpackage : spi_port_pkg

// [core/spi_clk_div.sv]
/*
  Half-period tick generator for master SCK: one pulse every 2**code clocks.
  Assumes run is low whenever the count should restart.
*/
`timescale 1ns/10ps
`default_nettype none

module spi_clk_div #(
  parameter int CODE_W = 3,
  parameter int CNT_W = 7
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic run_in,
  input wire logic [CODE_W-1:0] code_in,
  output logic tick_out
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } div_state_s;

  div_state_s s_q, s_d;
  logic [CNT_W-1:0] limit;

  always_comb begin
    limit = CNT_W'((CNT_W+1)'(1) << code_in) - CNT_W'(1);
    tick_out = run_in && (s_q.cnt == limit);
    s_d = s_q;
    if (!run_in || tick_out) begin
      s_d.cnt = '0;
    end else begin
      s_d.cnt = s_q.cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : spi_clk_div

`default_nettype wire

// [core/spi_shift8.sv]
/*
  Byte shift register with selectable bit order, used for transmit and receive.
  Assumes load and shift are never both needed in one clock.
*/
`timescale 1ns/10ps
`default_nettype none

module spi_shift8 #(
  parameter int W = 8
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic load_in,
  input wire logic [W-1:0] load_val_in,
  input wire logic shift_in,
  input wire logic bit_in,
  input wire logic lsb_first_in,
  output logic bit_out,
  output logic [W-1:0] data_out
);
  typedef struct packed {
    logic [W-1:0] data;
  } sh_state_s;

  sh_state_s s_q, s_d;

  always_comb begin
    s_d = s_q;
    if (load_in) begin
      s_d.data = load_val_in;
    end else if (shift_in) begin
      s_d.data = lsb_first_in ? {bit_in, s_q.data[W-1:1]} : {s_q.data[W-2:0], bit_in};
    end
    bit_out = lsb_first_in ? s_q.data[0] : s_q.data[W-1];
    data_out = s_q.data;
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : spi_shift8

`default_nettype wire

// [core/spi_port.sv]
/*
  SPI port with APB register access, master/slave byte engine and irq logic.
  Assumes APB master on mclk_in, pins synchronous to mclk_in, ss_n_in low
  selects the port in slave mode.
*/
// Added by the designer: the APB interface to the registers.
// How it works
// - changing control resets engine and buffers
// - master SCK divides clock by 2..256
// - order bit picks MSB or LSB first
// - role bit chooses slave or master
// - phase bit picks sample and shift edges
// - polarity bit sets idle SCK level
// - one address: write tx, read rx
// - data read/write clears rx/tx irq
// - clock enable gates master SCK driver
// - drive bits: immediate or after byte
// - pending index: 0, 3 rx, 4 tx
// - tx enable masks, reads raw state
// - rx enable masks, reads raw state
// - global aux enable gates irq output
`timescale 1ns/10ps
`default_nettype none
`include "spi_port_defs.svh"

module spi_port
  import spi_port_pkg::*;
#(
  parameter int W = 8
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [`SPI_ADDR_W-1:0] paddr_in,
  input wire logic [`SPI_DATA_W-1:0] pwdata_in,
  output logic [`SPI_DATA_W-1:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic ss_n_in,
  input wire spi_pin_s pins_in,
  output spi_pin_s pins_out,
  output spi_pin_s pins_oe_out,
  output logic irq_out
);
  core_state_s s_q, s_d;

  logic [9:0] idx;
  logic mapped, acc, wr, rd;
  logic [7:0] wb, rbyte;
  logic master, cpha, lsb_first;
  logic tick, edge_ev, sample, shift_tx, done;
  logic tx_load, rx_clear, flush;
  logic tx_bit, din;
  logic [W-1:0] rx_data, rx_next;
  logic [3:0] pending_aux_irq_index;
  logic irq_rx_p, irq_tx_p;

  assign master = s_q.ctrl[`SPI_MASTER_SELECT_BIT];
  assign cpha = s_q.ctrl[`SPI_CPHA_BIT];
  assign lsb_first = s_q.ctrl[`SPI_ORDER_BIT];
  assign idx = paddr_in[`SPI_ADDR_W-1:2];
  assign wb = pwdata_in[7:0];

  // one wait state: read data is registered before pready
  assign acc = psel_in && penable_in;
  // refused accesses neither write nor clear flags
  assign wr = acc && s_q.ack && pwrite_in && mapped;
  assign rd = acc && s_q.ack && !pwrite_in && mapped;
  assign pready_out = s_q.ack;
  assign prdata_out = s_q.rdata;

  always_comb begin
    mapped = (paddr_in[1:0] == 2'b00);
    case (idx)
      `SPI_IDX_CTRL, `SPI_IDX_DATA, `SPI_IDX_DRV, `SPI_IDX_PAI,
      `SPI_IDX_AIE, `SPI_IDX_STAT, `SPI_IDX_EXT: begin
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end
  assign pslverr_out = s_q.ack && !mapped;

  spi_clk_div u_div (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .run_in(master && (s_q.fsm == XF_RUN) && !flush),
    .code_in(s_q.ctrl[`SPI_DIV_HI:`SPI_DIV_LO]),
    .tick_out(tick)
  );

  // master edges come from the divider, slave edges from the sampled pin
  always_comb begin
    if (master) begin
      edge_ev = tick;
    end else begin
      edge_ev = (s_q.fsm == XF_RUN) && !ss_n_in && (pins_in.sck != s_q.sck_prev);
    end
  end

  assign sample = edge_ev && (s_q.cnt[0] == cpha);
  assign shift_tx = edge_ev && (s_q.cnt[0] != cpha) && !(cpha && s_q.cnt == 4'h0);
  assign done = edge_ev && (s_q.cnt == `SPI_LAST_EDGE);
  assign din = master ? pins_in.miso : pins_in.mosi;
  assign flush = wr && (idx == `SPI_IDX_CTRL) && ((wb & `SPI_RSVD_MASK) != s_q.ctrl);

  always_comb begin
    tx_load = 1'b0;
    rx_clear = 1'b0;
    if (flush) begin
      tx_load = 1'b1;
      rx_clear = 1'b1;
    end else if (s_q.fsm == XF_IDLE) begin
      if (master ? s_q.tx_full : !ss_n_in) begin
        tx_load = 1'b1;
        rx_clear = 1'b1;
      end
    end else if (done && !master) begin
      tx_load = 1'b1;
    end
  end

  spi_shift8 #(.W(W)) u_tx (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .load_in(tx_load),
    .load_val_in(flush ? `SPI_RST_BYTE : s_q.txb),
    .shift_in(shift_tx),
    .bit_in(1'b0),
    .lsb_first_in(lsb_first),
    .bit_out(tx_bit),
    .data_out()
  );

  spi_shift8 #(.W(W)) u_rx (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .load_in(rx_clear),
    .load_val_in(`SPI_RST_BYTE),
    .shift_in(sample),
    .bit_in(din),
    .lsb_first_in(lsb_first),
    .bit_out(),
    .data_out(rx_data)
  );

  // last sample of a phase-one byte lands on the done edge itself
  always_comb begin
    rx_next = rx_data;
    if (sample) begin
      rx_next = lsb_first ? {din, rx_data[W-1:1]} : {rx_data[W-2:0], din};
    end
  end

  assign irq_rx_p = s_q.rx_st && s_q.rx_msk;
  assign irq_tx_p = s_q.tx_st && s_q.tx_msk;

  always_comb begin
    if (irq_rx_p) begin
      pending_aux_irq_index = `SPI_PAI_RX;
    end else if (irq_tx_p) begin
      pending_aux_irq_index = `SPI_PAI_TX;
    end else begin
      pending_aux_irq_index = `SPI_PAI_NONE;
    end
  end

  always_comb begin
    rbyte = `SPI_RST_BYTE;
    case (idx)
      `SPI_IDX_CTRL: rbyte = s_q.ctrl;
      `SPI_IDX_DATA: rbyte = s_q.rxb;
      `SPI_IDX_DRV: begin
        rbyte[`SPI_CLK_EN_BIT] = s_q.clk_en;
        rbyte[`SPI_DRIVE_CHANGE_DEFERRED_BIT] = s_q.drv_pend;
        rbyte[`SPI_OUTPUT_DRIVE_ENABLE_BIT] = s_q.drv_pend ? s_q.drv_new : s_q.drv;
      end
      `SPI_IDX_PAI: rbyte[3:0] = pending_aux_irq_index;
      `SPI_IDX_AIE: begin
        rbyte[`SPI_IRQ_TX_BIT] = s_q.tx_st;
        rbyte[`SPI_IRQ_RX_BIT] = s_q.rx_st;
      end
      `SPI_IDX_STAT: begin
        rbyte[`SPI_IRQ_TX_BIT] = s_q.tx_st;
        rbyte[`SPI_IRQ_RX_BIT] = s_q.rx_st;
      end
      `SPI_IDX_EXT: rbyte[`SPI_EXT_AUX_BIT] = s_q.ext_en;
      default: rbyte = `SPI_RST_BYTE;
    endcase
  end

  always_comb begin
    s_d = s_q;
    s_d.sck_prev = pins_in.sck;
    s_d.ack = acc && !s_q.ack;
    if (acc && !s_q.ack) begin
      s_d.rdata = {{(`SPI_DATA_W-8){1'b0}}, (mapped ? rbyte : `SPI_RST_BYTE)};
    end
    // engine
    case (s_q.fsm)
      XF_IDLE: begin
        s_d.cnt = 4'h0;
        s_d.sck = 1'b0;
        if (tx_load) begin
          s_d.fsm = XF_RUN;
        end
      end
      XF_RUN: begin
        if (!master && ss_n_in) begin
          s_d.fsm = XF_IDLE;
        end else if (edge_ev) begin
          s_d.cnt = s_q.cnt + 4'h1;
          s_d.sck = master ? !s_q.sck : s_q.sck;
          if (done && master) begin
            s_d.fsm = XF_IDLE;
          end
        end
      end
      default: s_d.fsm = XF_IDLE;
    endcase
    if (done) begin
      s_d.rxb = rx_next;
      if (s_q.drv_pend) begin
        s_d.drv = s_q.drv_new;
        s_d.drv_pend = 1'b0;
      end
    end
    if (s_q.drv_pend && s_q.fsm == XF_IDLE) begin
      s_d.drv = s_q.drv_new;
      s_d.drv_pend = 1'b0;
    end
    if (tx_load && !flush) begin
      s_d.tx_full = 1'b0;
    end
    // software clears first, hardware sets win below
    if (rd && idx == `SPI_IDX_DATA) begin
      s_d.rx_st = 1'b0;
    end
    if (wr) begin
      case (idx)
        `SPI_IDX_CTRL: s_d.ctrl = wb & `SPI_RSVD_MASK;
        `SPI_IDX_DATA: begin
          s_d.txb = wb;
          s_d.tx_full = 1'b1;
          s_d.tx_st = 1'b0;
        end
        `SPI_IDX_DRV: begin
          s_d.clk_en = wb[`SPI_CLK_EN_BIT];
          if (wb[`SPI_DRIVE_CHANGE_DEFERRED_BIT] && s_q.fsm == XF_RUN) begin
            s_d.drv_pend = 1'b1;
            s_d.drv_new = wb[`SPI_OUTPUT_DRIVE_ENABLE_BIT];
          end else begin
            s_d.drv_pend = 1'b0;
            s_d.drv = wb[`SPI_OUTPUT_DRIVE_ENABLE_BIT];
          end
        end
        `SPI_IDX_AIE: begin
          s_d.tx_msk = wb[`SPI_IRQ_TX_BIT];
          s_d.rx_msk = wb[`SPI_IRQ_RX_BIT];
        end
        `SPI_IDX_STAT: begin
          s_d.tx_st = s_q.tx_st && !wb[`SPI_IRQ_TX_BIT];
          s_d.rx_st = s_q.rx_st && !wb[`SPI_IRQ_RX_BIT];
        end
        `SPI_IDX_EXT: s_d.ext_en = wb[`SPI_EXT_AUX_BIT];
        default: begin
        end
      endcase
    end
    if (done) begin
      s_d.rx_st = 1'b1;
    end
    if (tx_load && !flush && (master || s_q.tx_full)) begin
      s_d.tx_st = 1'b1;
    end
    if (flush) begin
      s_d.fsm = XF_IDLE;
      s_d.cnt = 4'h0;
      s_d.sck = 1'b0;
      s_d.tx_full = 1'b0;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // pins: master drives sck and mosi, slave drives miso
  always_comb begin
    pins_out.sck = s_q.ctrl[`SPI_CPOL_BIT] ^ s_q.sck;
    pins_out.mosi = tx_bit;
    pins_out.miso = tx_bit;
    pins_oe_out.sck = master && s_q.clk_en;
    pins_oe_out.mosi = master && s_q.drv;
    pins_oe_out.miso = !master && s_q.drv;
  end

  assign irq_out = s_q.ext_en && (irq_rx_p || irq_tx_p);

  idle_sck_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (s_q.fsm == XF_IDLE) |-> pins_out.sck == s_q.ctrl[`SPI_CPOL_BIT])
    else $error("sck not at idle level");
  sck_driver_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (wr && idx == `SPI_IDX_DRV) |=>
      pins_oe_out.sck == (master && $past(wb[`SPI_CLK_EN_BIT])))
    else $error("sck driven while disabled");
  rx_done_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    done |=> s_q.rx_st && s_q.rxb == $past(rx_next))
    else $error("byte done without rx flag");
  data_read_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (rd && idx == `SPI_IDX_DATA && !done) |=> !s_q.rx_st)
    else $error("rx flag not cleared by read");
  ctrl_flush_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    flush |=> s_q.fsm == XF_IDLE && s_q.cnt == 4'h0 && !s_q.tx_full)
    else $error("control change did not reset");
  pend_index_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (s_q.rx_st && s_q.rx_msk) |-> pending_aux_irq_index == `SPI_PAI_RX)
    else $error("pending index wrong");
  irq_gate_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    irq_out == (s_q.ext_en && pending_aux_irq_index != `SPI_PAI_NONE))
    else $error("irq without enabled source");
  drive_now_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (wr && idx == `SPI_IDX_DRV && !wb[`SPI_DRIVE_CHANGE_DEFERRED_BIT]) |=>
      s_q.drv == $past(wb[`SPI_OUTPUT_DRIVE_ENABLE_BIT]))
    else $error("immediate drive not applied");
  half_period_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (master && s_q.fsm == XF_RUN && s_q.ctrl[`SPI_DIV_HI:`SPI_DIV_LO] == 3'h1 && tick)
      |=> !tick ##1 (tick || s_q.fsm == XF_IDLE || flush))
    else $error("divide by four half period wrong");

  master_byte_c: cover property (@(posedge mclk_in) disable iff (!rst_n_in)
    done && master);
  slave_byte_c: cover property (@(posedge mclk_in) disable iff (!rst_n_in)
    done && !master);
  irq_fire_c: cover property (@(posedge mclk_in) disable iff (!rst_n_in)
    $rose(irq_out));
endmodule : spi_port

`default_nettype wire

// [tb/spi_peer.sv]
/*
  Behavioural far-side SPI device: slave to a master port, or master
  with a 4-clock half period. Assumes pins already resolved by the bench.
*/
`timescale 1ns/10ps
`default_nettype none

module spi_peer (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic cpol_in,
  input wire logic cpha_in,
  input wire logic lsb_in,
  input wire logic master_in,
  input wire logic start_in,
  input wire logic sel_n_in,
  input wire logic [7:0] tx_in,
  input wire logic sck_in,
  input wire logic data_in,
  output logic sck_out,
  output logic data_out,
  output logic [7:0] rx_out
);
  logic [4:0] k_q;
  logic [4:0] nk;
  logic [2:0] b;
  logic [1:0] div_q;
  logic run_q;
  logic prev_q;
  logic bit_q;
  wire sck_w = master_in ? sck_out : sck_in;

  // released line shows the inverse, never a stale copy
  assign data_out = sel_n_in ? ~bit_q : bit_q;

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      k_q <= 5'h00;
      div_q <= 2'h0;
      run_q <= 1'b0;
      prev_q <= 1'b0;
      bit_q <= 1'b0;
      sck_out <= 1'b0;
      rx_out <= 8'h00;
    end else begin
      prev_q <= sck_w;
      if (start_in) begin
        k_q <= 5'h00;
        run_q <= master_in;
        div_q <= 2'h0;
        sck_out <= cpol_in;
        bit_q <= tx_in[lsb_in ? 3'h0 : 3'h7];
      end else begin
        if (run_q) begin
          div_q <= div_q + 2'h1;
          if (div_q == 2'h3) sck_out <= ~sck_out;
        end
        if (sck_w !== prev_q && k_q < 5'h10) begin
          k_q <= k_q + 5'h01;
          b = k_q[3:1];
          if (k_q[0] == cpha_in) rx_out[lsb_in ? b : 3'h7 - b] <= data_in;
          nk = k_q + 5'h01;
          b = nk[3:1];
          if (k_q[0] != cpha_in && nk < 5'h10) bit_q <= tx_in[lsb_in ? b : 3'h7 - b];
          if (k_q == 5'h0F) run_q <= 1'b0;
        end
      end
    end
  end
endmodule : spi_peer

`default_nettype wire

// [tb/tb.sv]
/*
  Self-checking bench of the SPI port: APB tasks, partner device, verdict.
  Assumes one wait state per APB access and 100 MHz mclk.
*/
`timescale 1ns/10ps
`default_nettype none
`include "spi_port_defs.svh"

module tb;
  import spi_port_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic ss_n = 1'b1;
  logic irq;
  spi_pin_s pins_in;
  spi_pin_s pins_out;
  spi_pin_s pins_oe;
  logic p_cpol = 1'b0;
  logic p_cpha = 1'b0;
  logic p_lsb = 1'b0;
  logic p_master = 1'b0;
  logic p_start = 1'b0;
  logic p_sel_n = 1'b1;
  logic [7:0] p_tx = 8'h00;
  logic p_sck;
  logic p_dout;
  logic [7:0] p_rx;
  logic [31:0] rdv;
  logic errv;
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0;

  always #5 clk = ~clk;

  assign pins_in.sck = pins_oe.sck ? pins_out.sck : p_sck;
  assign pins_in.mosi = pins_oe.mosi ? pins_out.mosi : p_dout;
  assign pins_in.miso = pins_oe.miso ? pins_out.miso : p_dout;

  spi_port dut (
    .mclk_in(clk), .rst_n_in(rst_n), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .ss_n_in(ss_n), .pins_in(pins_in),
    .pins_out(pins_out), .pins_oe_out(pins_oe), .irq_out(irq)
  );

  spi_peer peer (
    .clk_in(clk), .rst_n_in(rst_n), .cpol_in(p_cpol), .cpha_in(p_cpha),
    .lsb_in(p_lsb), .master_in(p_master), .start_in(p_start), .sel_n_in(p_sel_n),
    .tx_in(p_tx), .sck_in(pins_in.sck),
    .data_in(p_master ? pins_in.miso : pins_in.mosi),
    .sck_out(p_sck), .data_out(p_dout), .rx_out(p_rx)
  );

  task automatic close_out();
    if (n_fail == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : close_out

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic acc(input logic w, input logic [9:0] idx, input logic [7:0] wd);
    int n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, wd};
    penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : acc

  task automatic wait_rx();
    int n = 0;
    rdv = 32'h00000000;
    while (rdv[2] !== 1'b1 && n < 1000) begin
      acc(1'b0, `SPI_IDX_AIE, 8'h00);
      n++;
    end
    chk(rdv[2], 1'b1);
  endtask : wait_rx

  // one full sck half period, measured between two toggles
  task automatic half(input int code);
    logic s;
    int n;
    s = pins_out.sck;
    n = 0;
    while (pins_out.sck === s && n < 600) begin
      @(posedge clk);
      n++;
    end
    s = pins_out.sck;
    n = 0;
    while (pins_out.sck === s && n < 600) begin
      @(posedge clk);
      n++;
    end
    chk(n, 1 << code);
  endtask : half

  task automatic peer_go(input logic [7:0] v);
    p_tx <= v;
    p_sel_n <= 1'b0;
    p_start <= 1'b1;
    @(posedge clk);
    p_start <= 1'b0;
  endtask : peer_go

  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      close_out();
    end
  end

  initial begin
    logic [9:0] regs [5];
    regs = '{`SPI_IDX_CTRL, `SPI_IDX_DATA, `SPI_IDX_DRV, `SPI_IDX_PAI, `SPI_IDX_AIE};
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    foreach (regs[i]) begin
      acc(1'b0, regs[i], 8'h00);
      chk(rdv, 32'h00000000);
    end
    acc(1'b0, 10'h09C, 8'h00);
    chk({errv, rdv}, 33'h100000000);
    acc(1'b1, `SPI_IDX_DRV, 8'h28);
    for (int m = 0; m < 8; m++) begin
      acc(1'b1, `SPI_IDX_CTRL, {3'h3, 1'b0, m[2], 1'b1, m[1], m[0]});
      {p_lsb, p_cpha, p_cpol} <= m[2:0];
      peer_go(8'hC5 + m);
      chk({pins_oe.sck, pins_out.sck}, {1'b1, m[0]});
      acc(1'b1, `SPI_IDX_DATA, 8'h36 ^ m);
      wait_rx();
      chk(p_rx, 8'h36 ^ m);
      if (m < 7) begin
        acc(1'b0, `SPI_IDX_DATA, 8'h00);
        chk(rdv, 8'hC5 + m);
        acc(1'b0, `SPI_IDX_AIE, 8'h00);
        chk(rdv, 32'h00000008);
      end
      p_sel_n <= 1'b1;
    end
    acc(1'b0, `SPI_IDX_AIE, 8'h00);
    chk(rdv, 32'h0000000C);
    acc(1'b0, `SPI_IDX_PAI, 8'h00);
    chk({irq, rdv}, 33'h000000000);
    acc(1'b1, `SPI_IDX_AIE, 8'h08);
    acc(1'b0, `SPI_IDX_PAI, 8'h00);
    chk({irq, rdv}, 33'h000000004);
    acc(1'b1, `SPI_IDX_EXT, 8'h10);
    chk(irq, 1'b1);
    acc(1'b1, `SPI_IDX_AIE, 8'h0C);
    acc(1'b0, `SPI_IDX_PAI, 8'h00);
    chk(rdv, 32'h00000003);
    acc(1'b0, `SPI_IDX_DATA, 8'h00);
    acc(1'b0, `SPI_IDX_PAI, 8'h00);
    chk(rdv, 32'h00000004);
    acc(1'b1, `SPI_IDX_STAT, 8'h08);
    acc(1'b0, `SPI_IDX_PAI, 8'h00);
    chk({irq, rdv}, 33'h000000000);
    acc(1'b1, `SPI_IDX_DATA, 8'hA7);
    acc(1'b1, `SPI_IDX_DRV, 8'h30);
    chk(pins_oe.mosi, 1'b1);
    wait_rx();
    chk(pins_oe.mosi, 1'b0);
    acc(1'b1, `SPI_IDX_DRV, 8'h38);
    chk(pins_oe.mosi, 1'b1);
    acc(1'b1, `SPI_IDX_DRV, 8'h20);
    chk(pins_oe, 3'b100);
    acc(1'b1, `SPI_IDX_DRV, 8'h08);
    chk(pins_oe, 3'b010);
    acc(1'b1, `SPI_IDX_DRV, 8'h28);
    acc(1'b0, `SPI_IDX_DATA, 8'h00);
    for (int c = 0; c < 8; c++) begin
      acc(1'b1, `SPI_IDX_CTRL, {c[2:0], 5'h04});
      acc(1'b1, `SPI_IDX_DATA, 8'h5A);
      half(c);
      // changed control mid-byte must abandon it
      acc(1'b1, `SPI_IDX_CTRL, {c[2:0], 5'h05});
      repeat (16 << c) @(posedge clk);
      acc(1'b0, `SPI_IDX_AIE, 8'h00);
      chk({pins_out.sck, rdv[2]}, 2'b10);
    end
    acc(1'b1, `SPI_IDX_CTRL, 8'h00);
    acc(1'b1, `SPI_IDX_DATA, 8'h93);
    {p_lsb, p_cpha, p_cpol} <= 3'h0;
    p_master <= 1'b1;
    ss_n <= 1'b0;
    peer_go(8'h4E);
    wait_rx();
    ss_n <= 1'b1;
    p_sel_n <= 1'b1;
    acc(1'b0, `SPI_IDX_DATA, 8'h00);
    chk(rdv, 32'h0000004E);
    chk(p_rx, 8'h93);
    acc(1'b1, `SPI_IDX_DATA, 8'h11);
    acc(1'b0, `SPI_IDX_AIE, 8'h00);
    chk(rdv, 32'h00000000);
    close_out();
  end
endmodule : tb

`default_nettype wire
